// File: rtl/dlsc_defines.svh
// command codes, field positions, reset values and widths of the config bank
`ifndef DLSC_DEFINES_SVH
`define DLSC_DEFINES_SVH
`define DLSC_CMD_NONOVERLAP 8'hdd
`define DLSC_CMD_ADAPT_CFG 8'hde
`define DLSC_CMD_LOOP_TUNE 8'hdf
`define DLSC_CMD_RAIL_ORDER 8'he0
`define DLSC_RST_NONOVERLAP 16'h1010
`define DLSC_RST_ADAPT_CFG 16'h8888
`define DLSC_RST_LOOP_TUNE 25'h15a0190
`define DLSC_RST_RAIL_ORDER 16'h0000
`define DLSC_LEN_SHORT 3'h2
`define DLSC_LEN_LONG 3'h4
`define DLSC_DT_HL_MSB 15
`define DLSC_DT_HL_LSB 8
`define DLSC_DT_LH_MSB 7
`define DLSC_DT_LH_LSB 0
`define DLSC_ACFG_HL_FRZ 15
`define DLSC_ACFG_HL_MIN_MSB 14
`define DLSC_ACFG_HL_MIN_LSB 8
`define DLSC_ACFG_LH_FRZ 7
`define DLSC_ACFG_LH_MIN_MSB 6
`define DLSC_ACFG_LH_MIN_LSB 0
`define DLSC_LOOP_EN 24
`define DLSC_LOOP_RES_MSB 23
`define DLSC_LOOP_RES_LSB 16
`define DLSC_LOOP_GAIN_MSB 15
`define DLSC_LOOP_GAIN_LSB 0
`define DLSC_ORD_PRE_EN 15
`define DLSC_ORD_PRE_ID_MSB 12
`define DLSC_ORD_PRE_ID_LSB 8
`define DLSC_ORD_SEQ_EN 7
`define DLSC_ORD_SEQ_ID_MSB 4
`define DLSC_ORD_SEQ_ID_LSB 0
`define DLSC_ORD_MASK 16'h9f9f
`endif

// File: rtl/dlsc_pkg.sv
// types shared by the dead-time, loop and sequencing config bank
package dlsc_pkg;
  typedef enum logic [1:0] {
    DLSC_RAIL_OFF,
    DLSC_RAIL_ON,
    DLSC_RAIL_DELAY
  } dlsc_rail_e;
  typedef logic signed [7:0] dlsc_dt_t;
endpackage

// File: rtl/dlsc_config_bank.sv
// dead-time, charge loop tuning and rail sequencing command bank
`include "dlsc_defines.svh"
module dlsc_config_bank
  import dlsc_pkg::*;
#(
  parameter int OFF_DLY_W = 16
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [7:0] i_cmd_code,
  input wire logic [2:0] i_cmd_len,
  input wire logic [31:0] i_cmd_wdata,
  input wire logic signed [7:0] i_adapt_dt_hl,
  input wire logic signed [7:0] i_adapt_dt_lh,
  input wire logic i_en_state,
  input wire logic [OFF_DLY_W-1:0] i_off_dly,
  input wire logic i_bus_pg_evt,
  input wire logic i_bus_pd_evt,
  input wire logic [4:0] i_bus_evt_id,
  output logic o_cmd_rvalid,
  output logic o_cmd_nack,
  output logic [2:0] o_cmd_rlen,
  output logic [31:0] o_cmd_rdata,
  output logic signed [7:0] o_dt_hl,
  output logic signed [7:0] o_dt_lh,
  output logic o_hl_overlap,
  output logic o_lh_overlap,
  output logic signed [7:0] o_dt_hl_max,
  output logic signed [7:0] o_dt_lh_max,
  output logic o_loop_en,
  output logic [7:0] o_loop_residual,
  output logic [15:0] o_loop_gain,
  output logic o_out_enable
);

  logic [15:0] fet_nonoverlap_time;
  logic [15:0] nonoverlap_adapt_cfg;
  logic [24:0] charge_loop_tuning;
  logic [15:0] rail_order_link;
  logic last_wr_nonoverlap;
  logic pg_seen;
  logic seq_down;
  logic [OFF_DLY_W-1:0] off_cnt;
  dlsc_rail_e rail_st;
  logic len_ok;
  logic pg_hit;
  logic pd_hit;
  dlsc_dt_t next_dt_hl;
  dlsc_dt_t next_dt_lh;

  // clamp an adaptive dead time between the 2 ns-step minimum and the maximum
  function automatic dlsc_dt_t dt_clamp(input dlsc_dt_t v,
                                        input logic [6:0] min_f,
                                        input dlsc_dt_t hi);
    logic signed [8:0] lo;
    dlsc_dt_t r;
    lo = $signed({1'b0, min_f, 1'b0});
    r = v;
    if (r > hi)
    begin
      r = hi;
    end
    if ($signed({r[7], r}) < lo)
    begin
      r = (lo > 9'sh07f) ? 8'sh7f : dlsc_dt_t'(lo[7:0]);
    end
    return r;
  endfunction

  // loop tuning takes exactly four bytes, the others two
  always_comb
  begin
    if (i_cmd_code == `DLSC_CMD_LOOP_TUNE)
    begin
      len_ok = (i_cmd_len == `DLSC_LEN_LONG);
    end
    else
    begin
      len_ok = (i_cmd_len == `DLSC_LEN_SHORT);
    end
  end

  // command writes; a short or long mismatch is dropped, not half-applied
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      fet_nonoverlap_time <= `DLSC_RST_NONOVERLAP;
      nonoverlap_adapt_cfg <= `DLSC_RST_ADAPT_CFG;
      charge_loop_tuning <= `DLSC_RST_LOOP_TUNE;
      rail_order_link <= `DLSC_RST_RAIL_ORDER;
    end
    else if (i_ce && i_cmd_wr && len_ok)
    begin
      unique case (i_cmd_code)
        `DLSC_CMD_NONOVERLAP: fet_nonoverlap_time <= i_cmd_wdata[15:0];
        `DLSC_CMD_ADAPT_CFG: nonoverlap_adapt_cfg <= i_cmd_wdata[15:0];
        `DLSC_CMD_LOOP_TUNE: charge_loop_tuning <= i_cmd_wdata[24:0];
        `DLSC_CMD_RAIL_ORDER:
          rail_order_link <= i_cmd_wdata[15:0] & `DLSC_ORD_MASK;
        default: ;
      endcase
    end
  end

  // the maximum is only taken when the config write directly follows
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      last_wr_nonoverlap <= 1'b0;
      o_dt_hl_max <= 8'sh10;
      o_dt_lh_max <= 8'sh10;
    end
    else if (i_ce && i_cmd_wr && len_ok)
    begin
      last_wr_nonoverlap <= (i_cmd_code == `DLSC_CMD_NONOVERLAP);
      if (last_wr_nonoverlap && i_cmd_code == `DLSC_CMD_ADAPT_CFG)
      begin
        o_dt_hl_max <= fet_nonoverlap_time[`DLSC_DT_HL_MSB:`DLSC_DT_HL_LSB];
        o_dt_lh_max <= fet_nonoverlap_time[`DLSC_DT_LH_MSB:`DLSC_DT_LH_LSB];
      end
    end
  end

  // read answers come one cycle after the request
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_cmd_rvalid <= 1'b0;
      o_cmd_nack <= 1'b0;
      o_cmd_rlen <= 3'h0;
      o_cmd_rdata <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      o_cmd_rvalid <= i_cmd_rd;
      o_cmd_nack <= 1'b0;
      o_cmd_rlen <= `DLSC_LEN_SHORT;
      o_cmd_rdata <= 32'h0000_0000;
      if (i_cmd_rd)
      begin
        unique case (i_cmd_code)
          `DLSC_CMD_NONOVERLAP: o_cmd_rdata <= {16'h0000, fet_nonoverlap_time};
          `DLSC_CMD_ADAPT_CFG: o_cmd_rdata <= {16'h0000, nonoverlap_adapt_cfg};
          `DLSC_CMD_LOOP_TUNE:
          begin
            o_cmd_rdata <= {7'h00, charge_loop_tuning};
            o_cmd_rlen <= `DLSC_LEN_LONG;
          end
          `DLSC_CMD_RAIL_ORDER: o_cmd_rdata <= {16'h0000, rail_order_link};
          default:
          begin
            o_cmd_nack <= 1'b1;
            o_cmd_rlen <= 3'h0;
          end
        endcase
      end
    end
  end

  // frozen transitions use the stored value, adaptive ones are clamped
  always_comb
  begin
    if (nonoverlap_adapt_cfg[`DLSC_ACFG_HL_FRZ])
    begin
      next_dt_hl = fet_nonoverlap_time[`DLSC_DT_HL_MSB:`DLSC_DT_HL_LSB];
    end
    else
    begin
      next_dt_hl = dt_clamp(i_adapt_dt_hl,
        nonoverlap_adapt_cfg[`DLSC_ACFG_HL_MIN_MSB:`DLSC_ACFG_HL_MIN_LSB],
        o_dt_hl_max);
    end
    if (nonoverlap_adapt_cfg[`DLSC_ACFG_LH_FRZ])
    begin
      next_dt_lh = fet_nonoverlap_time[`DLSC_DT_LH_MSB:`DLSC_DT_LH_LSB];
    end
    else
    begin
      next_dt_lh = dt_clamp(i_adapt_dt_lh,
        nonoverlap_adapt_cfg[`DLSC_ACFG_LH_MIN_MSB:`DLSC_ACFG_LH_MIN_LSB],
        o_dt_lh_max);
    end
  end

  // host keeps values in -15..60 ns, so no range check is made here
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_dt_hl <= 8'sh10;
      o_dt_lh <= 8'sh10;
      o_hl_overlap <= 1'b0;
      o_lh_overlap <= 1'b0;
    end
    else if (i_ce)
    begin
      o_dt_hl <= next_dt_hl;
      o_dt_lh <= next_dt_lh;
      o_hl_overlap <= next_dt_hl[7];
      o_lh_overlap <= next_dt_lh[7];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_loop_en <= 1'b1;
      o_loop_residual <= 8'h5a;
      o_loop_gain <= 16'h0190;
    end
    else if (i_ce)
    begin
      o_loop_en <= charge_loop_tuning[`DLSC_LOOP_EN];
      o_loop_residual <=
        charge_loop_tuning[`DLSC_LOOP_RES_MSB:`DLSC_LOOP_RES_LSB];
      o_loop_gain <=
        charge_loop_tuning[`DLSC_LOOP_GAIN_MSB:`DLSC_LOOP_GAIN_LSB];
    end
  end

  assign pg_hit = i_bus_pg_evt && rail_order_link[`DLSC_ORD_PRE_EN] &&
    (i_bus_evt_id == rail_order_link[`DLSC_ORD_PRE_ID_MSB:`DLSC_ORD_PRE_ID_LSB]);
  assign pd_hit = i_bus_pd_evt && rail_order_link[`DLSC_ORD_SEQ_EN] &&
    (i_bus_evt_id == rail_order_link[`DLSC_ORD_SEQ_ID_MSB:`DLSC_ORD_SEQ_ID_LSB]);

  // power-good memory; an event in the clearing cycle still sets it
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      pg_seen <= 1'b0;
      seq_down <= 1'b0;
    end
    else if (i_ce)
    begin
      if (pg_hit)
      begin
        pg_seen <= 1'b1;
      end
      else if (!i_en_state)
      begin
        pg_seen <= 1'b0;
      end
      if (pd_hit && rail_st != DLSC_RAIL_OFF)
      begin
        seq_down <= 1'b1;
      end
      else if (!i_en_state)
      begin
        seq_down <= 1'b0;
      end
    end
  end

  // a sequel shutdown holds the rail off until the enable state drops
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      rail_st <= DLSC_RAIL_OFF;
      off_cnt <= '0;
      o_out_enable <= 1'b0;
    end
    else if (i_ce)
    begin
      unique case (rail_st)
        DLSC_RAIL_OFF:
          if (i_en_state && !seq_down &&
              (!rail_order_link[`DLSC_ORD_PRE_EN] || pg_seen))
          begin
            rail_st <= DLSC_RAIL_ON;
            o_out_enable <= 1'b1;
          end
        DLSC_RAIL_ON:
          if (!i_en_state || pd_hit)
          begin
            rail_st <= DLSC_RAIL_DELAY;
            off_cnt <= i_off_dly;
          end
        DLSC_RAIL_DELAY:
          if (off_cnt == '0)
          begin
            rail_st <= DLSC_RAIL_OFF;
            o_out_enable <= 1'b0;
          end
          else
          begin
            off_cnt <= off_cnt - 1'b1;
          end
      endcase
    end
  end

endmodule

// File: dv/dlsc_config_bank_properties.sv
// port checker for the config bank
module dlsc_config_bank_properties (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_cmd_rd,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_en_state,
  input wire logic o_cmd_rvalid,
  input wire logic o_cmd_nack,
  input wire logic [2:0] o_cmd_rlen,
  input wire logic [31:0] o_cmd_rdata,
  input wire logic signed [7:0] o_dt_hl,
  input wire logic signed [7:0] o_dt_lh,
  input wire logic o_hl_overlap,
  input wire logic o_lh_overlap,
  input wire logic o_out_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);
  a_loop_len: assert property (i_ce && i_cmd_rd &&
    i_cmd_code == 8'hdf |=> o_cmd_rvalid && o_cmd_rlen == 3'h4)
    else $error("loop read length wrong");
  // a frozen cycle holds the last answer, so only enabled idle cycles count
  a_no_spur: assert property (i_ce && !i_cmd_rd |=> !o_cmd_rvalid)
    else $error("unrequested read answer");
  a_rail_zero: assert property (o_cmd_rvalid &&
    $past(i_cmd_code) == 8'he0 |-> (o_cmd_rdata & 32'hffff6060) == 0)
    else $error("unused rail bits set");
  a_loop_zero: assert property (o_cmd_rvalid |-> !(|o_cmd_rdata[31:25]))
    else $error("unused loop bits set");
  a_hl_sign: assert property (o_hl_overlap == o_dt_hl[7])
    else $error("hl overlap flag wrong");
  a_lh_sign: assert property (o_lh_overlap == o_dt_lh[7])
    else $error("lh overlap flag wrong");
  a_nack_empty: assert property (o_cmd_nack |-> o_cmd_rvalid &&
    o_cmd_rlen == 3'h0 && o_cmd_rdata == 32'h0)
    else $error("refused read not empty");
  a_en_cause: assert property ($rose(o_out_enable) |->
    $past(i_en_state))
    else $error("output on without enable state");
  c_nack: cover property (o_cmd_nack);
  c_on: cover property ($rose(o_out_enable));
  c_off: cover property ($fell(o_out_enable));
endmodule
bind dlsc_config_bank dlsc_config_bank_properties i_props (
  .i_clk_sys, .i_rst_b, .i_ce, .i_cmd_rd, .i_cmd_code, .i_en_state,
  .o_cmd_rvalid, .o_cmd_nack, .o_cmd_rlen, .o_cmd_rdata, .o_dt_hl,
  .o_dt_lh, .o_hl_overlap, .o_lh_overlap, .o_out_enable
);

// File: dv/dlsc_peer_model.sv
// peer controller raising events on the inter-chip bus
module dlsc_peer_model (
  input wire logic i_clk_sys,
  output logic o_pg_evt = 1'b0,
  output logic o_pd_evt = 1'b0,
  output logic [4:0] o_evt_id = 5'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle id is inverted so a stale id can never match
  task send(input logic pd, input logic [4:0] id);
    @(posedge i_clk_sys);
    o_pg_evt <= !pd;
    o_pd_evt <= pd;
    o_evt_id <= id;
    @(posedge i_clk_sys);
    o_pg_evt <= 1'b0;
    o_pd_evt <= 1'b0;
    o_evt_id <= ~id;
  endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the config bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en = 1'b0;
  logic [7:0] code = 8'h00;
  logic [2:0] len = 3'h0;
  logic [31:0] wd = 32'h0;
  logic signed [7:0] ahl = 8'h00;
  logic signed [7:0] alh = 8'h00;
  logic [15:0] dly = 16'h0003;
  wire logic pg, pd, rv, nk, ohl, olh, lpe, oen;
  wire logic [4:0] eid;
  wire logic [2:0] rl;
  wire logic [31:0] rdat;
  wire logic signed [7:0] dhl, dlh, mhl, mlh;
  wire logic [7:0] res;
  wire logic [15:0] gain;
  int err_total = 0;
  int checks = 0;
  dlsc_peer_model i_peer (.i_clk_sys(clk), .o_pg_evt(pg), .o_pd_evt(pd),
    .o_evt_id(eid));
  dlsc_config_bank #(.OFF_DLY_W(16)) i_dut (.i_clk_sys(clk),
    .i_rst_b(rst_b), .i_ce(ce), .i_cmd_wr(wr), .i_cmd_rd(rd),
    .i_cmd_code(code), .i_cmd_len(len), .i_cmd_wdata(wd),
    .i_adapt_dt_hl(ahl), .i_adapt_dt_lh(alh), .i_en_state(en),
    .i_off_dly(dly), .i_bus_pg_evt(pg), .i_bus_pd_evt(pd),
    .i_bus_evt_id(eid), .o_cmd_rvalid(rv), .o_cmd_nack(nk),
    .o_cmd_rlen(rl), .o_cmd_rdata(rdat), .o_dt_hl(dhl), .o_dt_lh(dlh),
    .o_hl_overlap(ohl), .o_lh_overlap(olh), .o_dt_hl_max(mhl),
    .o_dt_lh_max(mlh), .o_loop_en(lpe), .o_loop_residual(res),
    .o_loop_gain(gain), .o_out_enable(oen));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task wrc(input logic [7:0] c, input logic [2:0] l, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    code <= c;
    len <= l;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] c, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    code <= c;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, rv);
    chk("rdata", e, rdat);
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_reset;
    rdc(8'hdd, 32'h1010);
    rdc(8'hde, 32'h8888);
    rdc(8'hdf, 32'h015a0190);
    rdc(8'he0, 32'h0);
    chk("gain", 32'h190, gain);
    chk("residual", 32'h5a, res);
    chk("dt_hl", 32'h10, {dhl});
    chk("dt_lh", 32'h10, {dlh});
    chk("loop_en", 32'h1, lpe);
    chk("hl_max", 32'h10, {mhl});
  endtask
  task t_dead;
    wrc(8'hdd, 3'h2, 32'hf13c);
    settle;
    chk("dt_hl", 32'hf1, {dhl});
    chk("dt_lh", 32'h3c, {dlh});
    chk("hl_ovl", 32'h1, ohl);
    chk("lh_ovl", 32'h0, olh);
    rdc(8'hdd, 32'hf13c);
    chk("rlen_short", 32'h2, rl);
  endtask
  task t_adapt;
    @(posedge clk);
    ahl <= 8'h32;
    alh <= 8'h05;
    wrc(8'hdd, 3'h2, 32'h201e);
    wrc(8'hde, 3'h2, 32'h0a0b);
    settle;
    chk("hl_max", 32'h20, {mhl});
    chk("lh_max", 32'h1e, {mlh});
    chk("hl_cap", 32'h20, {dhl});
    chk("lh_floor", 32'h16, {dlh});
    @(posedge clk);
    ahl <= 8'h02;
    alh <= 8'h1a;
    settle;
    chk("hl_floor", 32'h14, {dhl});
    chk("lh_pass", 32'h1a, {dlh});
    wrc(8'hde, 3'h2, 32'h8888);
    settle;
    chk("hl_frz", 32'h20, {dhl});
    chk("lh_frz", 32'h1e, {dlh});
  endtask
  // a write while the clock enable is low must leave the register alone
  task t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wrc(8'hdd, 3'h2, 32'h0505);
    ce <= 1'b1;
    rdc(8'hdd, 32'h201e);
  endtask
  task t_loop;
    wrc(8'hdf, 3'h4, 32'hfe12abcd);
    rdc(8'hdf, 32'h0012abcd);
    chk("rlen", 32'h4, rl);
    chk("loop_en", 32'h0, lpe);
    chk("residual", 32'h12, res);
    chk("gain", 32'habcd, gain);
    wrc(8'hdf, 3'h2, 32'h01000001);
    rdc(8'hdf, 32'h0012abcd);
    rdc(8'he1, 32'h0);
    chk("nack", 32'h1, nk);
  endtask
  task t_seq;
    wrc(8'he0, 3'h2, 32'hffff);
    rdc(8'he0, 32'h9f9f);
    wrc(8'he0, 3'h2, 32'h8583);
    rdc(8'he0, 32'h8583);
    @(posedge clk);
    en <= 1'b1;
    i_peer.send(1'b0, 5'h04);
    settle;
    chk("out_wait", 32'h0, oen);
    i_peer.send(1'b0, 5'h05);
    settle;
    chk("out_on", 32'h1, oen);
    i_peer.send(1'b1, 5'h03);
    repeat (3) @(posedge clk);
    #1;
    chk("out_dly", 32'h1, oen);
    @(posedge clk);
    #1;
    chk("out_off", 32'h0, oen);
    settle;
    chk("out_held", 32'h0, oen);
    @(posedge clk);
    en <= 1'b0;
    wrc(8'he0, 3'h2, 32'h0000);
    @(posedge clk);
    en <= 1'b1;
    settle;
    chk("out_free", 32'h1, oen);
    @(posedge clk);
    en <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("out_en_off", 32'h0, oen);
  endtask
  initial
  begin
    #20000;
    err_total++;
    $display("[FAIL] watchdog exp done got hang");
    conclude;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_dead;
    t_adapt;
    t_freeze;
    t_loop;
    t_seq;
    conclude;
  end
endmodule
